// file: logic/adc_gain_autozero_format_config.sv
// gain / auto-zero and conversion-end / output-format configuration with conversion sequencing
`timescale 1ns/1ps
module adc_gain_autozero_format_config
  import adc_cfg_pkg::*;
#(
  parameter int BASE_CONV_CYCLES = CONV_CYCLES
)(
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic        op_state_wr_in,
  input  wire logic [1:0]  op_state_in,
  input  wire logic        internal_ref_sel_in,
  input  wire logic [24:0] raw_result_in,
  input  wire logic [3:0]  channel_tag_in,
  input  wire logic        scan_cycle_last_in,
  output logic      [7:0]  reg_rdata_out,
  output logic      [1:0]  bias_current_select_out,
  output logic      [2:0]  analog_gain_out,
  output logic             input_mux_autozero_out,
  output logic             reference_buffer_chop_out,
  output logic      [1:0]  op_state_out,
  output logic      [31:0] data_word_out,
  output logic             data_word32_out,
  output logic             data_valid_out
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [7:0]  gain_az_cfg;
    logic [7:0]  conv_fmt_cfg;
    logic [1:0]  op_state;
    conv_state_t seq;
    logic [15:0] cnt;
    logic [7:0]  rdata;
    logic [2:0]  analog_gain;
    logic        chop;
    logic [31:0] word;
    logic        word32;
    logic        valid;
    logic [1:0]  word_fmt;
  } ctl_state_t;

  localparam ctl_state_t CTL_RESET = '{
    gain_az_cfg:  GAIN_AZ_CFG_RESET,
    conv_fmt_cfg: CONV_FMT_CFG_RESET,
    op_state:     OP_STATE_RESET,
    seq:          ST_IDLE,
    cnt:          16'h0000,
    rdata:        8'h00,
    analog_gain:  3'h1,
    chop:         1'b0,
    word:         32'h0000_0000,
    word32:       1'b0,
    valid:        1'b0,
    word_fmt:     2'h0
  };

  ctl_state_t s_q;
  ctl_state_t s_d;

  logic [31:0] fmt_word;
  logic        fmt_word32;
  logic [2:0]  gain_code;
  logic [1:0]  end_action;
  logic        autozero;
  logic        conv_done;

  assign gain_code  = s_q.gain_az_cfg[GAIN_LSB +: 3];
  assign end_action = s_q.conv_fmt_cfg[END_ACTION_LSB +: 2];
  assign autozero   = s_q.gain_az_cfg[AUTOZERO_BIT];
  assign conv_done  = (s_q.seq == ST_CONVERT) && (s_q.cnt == 16'h0000);

  function automatic logic [15:0] conv_len(input logic az);
    conv_len = az ? 16'(2 * BASE_CONV_CYCLES - 1) : 16'(BASE_CONV_CYCLES - 1);
  endfunction

  // ==========================================================================
  // result packing
  // ==========================================================================
  result_formatter u_fmt (
    .raw_result_in  (raw_result_in),
    .gain_code_in   (gain_code),
    .format_in      (s_q.conv_fmt_cfg[FORMAT_LSB +: 2]),
    .channel_tag_in (channel_tag_in),
    .word_out       (fmt_word),
    .word32_out     (fmt_word32)
  );

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    s_d       = s_q;
    s_d.valid = 1'b0;
    if (reg_wr_in && reg_addr_in == GAIN_AZ_CFG_ADDR) begin
      s_d.gain_az_cfg = reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == CONV_FMT_CFG_ADDR) begin
      s_d.conv_fmt_cfg = reg_wdata_in;
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        GAIN_AZ_CFG_ADDR:  s_d.rdata = s_q.gain_az_cfg;
        CONV_FMT_CFG_ADDR: s_d.rdata = s_q.conv_fmt_cfg;
        default:           s_d.rdata = 8'h00;
      endcase
    end
    // x64 and x32 both use the x16 analog stage; the rest is digital
    s_d.analog_gain = (gain_code == GAIN_X64 || gain_code == GAIN_X32) ? GAIN_X16 : gain_code;
    s_d.chop        = s_q.gain_az_cfg[REF_CHOP_BIT] && internal_ref_sel_in;
    if (op_state_wr_in) begin
      s_d.op_state = op_state_in;
    end
    unique case (s_q.seq)
      ST_IDLE: begin
        if (s_q.op_state == OP_CONVERTING) begin
          s_d.seq = ST_CONVERT;
          s_d.cnt = conv_len(autozero);
        end
      end
      ST_CONVERT: begin
        if (s_q.op_state != OP_CONVERTING) begin
          s_d.seq = ST_IDLE;
        end else if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.valid    = 1'b1;
          s_d.word     = fmt_word;
          s_d.word32   = fmt_word32;
          s_d.word_fmt = s_q.conv_fmt_cfg[FORMAT_LSB +: 2];
          s_d.cnt      = conv_len(autozero);
          if (scan_cycle_last_in) begin
            unique case (end_action)
              END_CONTINUOUS: begin
                if (autozero) begin
                  s_d.seq = ST_REARM;
                end
              end
              END_STANDBY: begin
                s_d.op_state = OP_STANDBY;
                s_d.seq      = ST_IDLE;
              end
              default: begin
                s_d.op_state = OP_SHUTDOWN;
                s_d.seq      = ST_IDLE;
              end
            endcase
          end
        end
      end
      ST_REARM: begin
        s_d.seq = ST_IDLE;
      end
      default: begin
        s_d.seq = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out             = s_q.rdata;
  assign bias_current_select_out   = s_q.gain_az_cfg[BIAS_SEL_LSB +: 2];
  assign analog_gain_out           = s_q.analog_gain;
  assign input_mux_autozero_out    = s_q.gain_az_cfg[AUTOZERO_BIT];
  assign reference_buffer_chop_out = s_q.chop;
  assign op_state_out              = s_q.op_state;
  assign data_word_out             = s_q.word;
  assign data_word32_out           = s_q.word32;
  assign data_valid_out            = s_q.valid;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  logic [15:0] len_q;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      len_q <= 16'h0000;
    end else if (s_q.seq == ST_CONVERT && !conv_done) begin
      len_q <= len_q + 16'h0001;
    end else begin
      len_q <= 16'h0000;
    end
  end

  sequence seq_cycle_end;
    conv_done && s_q.op_state == OP_CONVERTING && scan_cycle_last_in && !op_state_wr_in;
  endsequence

  sequence seq_fresh_start;
    s_q.seq == ST_IDLE ##1 s_q.seq == ST_CONVERT;
  endsequence

  chk_conv_length: assert property (
    seq_fresh_start ##0 (s_q.op_state == OP_CONVERTING) [*2] ##0 !$changed(autozero) |->
      ##[0:300] ((conv_done && len_q == conv_len(autozero)) ||
                 (op_state_wr_in && !conv_done)))
    else $error("conversion length does not match auto-zero setting");

  chk_end_standby: assert property (
    seq_cycle_end and (end_action == END_STANDBY) |=> s_q.op_state == OP_STANDBY ##1 s_q.seq == ST_IDLE)
    else $error("one-shot did not end in standby");

  chk_end_shutdown: assert property (
    seq_cycle_end and (end_action[1] == 1'b0) |=> s_q.op_state == OP_SHUTDOWN && data_valid_out)
    else $error("one-shot did not end in shutdown");

  chk_cont_stays: assert property (
    seq_cycle_end and (end_action == END_CONTINUOUS) && !autozero |=> s_q.op_state == OP_CONVERTING && s_q.seq == ST_CONVERT)
    else $error("continuous conversion stopped");

  chk_az_rearm: assert property (
    seq_cycle_end and (end_action == END_CONTINUOUS) && autozero |=> s_q.seq == ST_REARM ##1 s_q.seq == ST_IDLE)
    else $error("auto-zero continuous not split into single conversions");

  chk_analog_cap: assert property (
    gain_code[2:1] == 2'h3 |=> analog_gain_out == GAIN_X16)
    else $error("high gain codes must use x16 analog stage");

  chk_chop_extref: assert property (
    !internal_ref_sel_in |=> !reference_buffer_chop_out)
    else $error("chopping active with external reference");

  chk_fmt_sign8: assert property (
    data_valid_out && s_q.word_fmt == FMT_SIGN32 |->
      data_word_out[31:25] == {7{data_word_out[24]}} && data_word32_out)
    else $error("eight sign bits not consistent");

  chk_fmt_bare: assert property (
    data_valid_out && s_q.word_fmt == FMT_BARE24 |-> data_word_out[31:24] == 8'h00 && !data_word32_out)
    else $error("bare format upper byte not zero");

endmodule

// file: shared/adc_cfg_pkg.sv
// constants and types shared by the gain, auto-zero and output format configuration block
package adc_cfg_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [7:0] GAIN_AZ_CFG_ADDR      = 8'h03;
  localparam logic [7:0] CONV_FMT_CFG_ADDR     = 8'h04;
  localparam logic [7:0] GAIN_AZ_CFG_RESET     = 8'h8B;
  localparam logic [7:0] CONV_FMT_CFG_RESET    = 8'h00;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int BIAS_SEL_LSB      = 6;
  localparam int GAIN_LSB          = 3;
  localparam int AUTOZERO_BIT      = 2;
  localparam int REF_CHOP_BIT      = 1;
  localparam int RESERVED_BIT      = 0;
  localparam int END_ACTION_LSB    = 6;
  localparam int FORMAT_LSB        = 4;

  // ==========================================================================
  // codes
  // ==========================================================================
  localparam logic [2:0] GAIN_X16         = 3'h5;
  localparam logic [2:0] GAIN_X32         = 3'h6;
  localparam logic [2:0] GAIN_X64         = 3'h7;
  localparam logic [1:0] OP_CONVERTING    = 2'h3;
  localparam logic [1:0] OP_STANDBY       = 2'h2;
  localparam logic [1:0] OP_SHUTDOWN      = 2'h0;
  localparam logic [1:0] OP_STATE_RESET   = 2'h0;
  localparam logic [1:0] END_CONTINUOUS   = 2'h3;
  localparam logic [1:0] END_STANDBY      = 2'h2;
  localparam logic [1:0] FMT_TAG_SIGN32   = 2'h3;
  localparam logic [1:0] FMT_SIGN32       = 2'h2;
  localparam logic [1:0] FMT_LEFT32       = 2'h1;
  localparam logic [1:0] FMT_BARE24       = 2'h0;
  localparam logic [23:0] POS_CLAMP_24    = 24'hFFFFFF;
  localparam logic [23:0] NEG_CLAMP_24    = 24'h800000;
  localparam logic [24:0] POS_MAX_25      = 25'h0FFFFFF;
  localparam logic [24:0] NEG_MAX_25      = 25'h1000000;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS     = 25;
  localparam int CONV_TIME_NS      = 400;
  localparam int CONV_CYCLES       = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_REARM
  } conv_state_t;

endpackage

// file: logic/result_formatter.sv
// digital gain, saturation and output word packing of one conversion result
`timescale 1ns/1ps
module result_formatter
  import adc_cfg_pkg::*;
(
  input  wire logic [24:0] raw_result_in,
  input  wire logic [2:0]  gain_code_in,
  input  wire logic [1:0]  format_in,
  input  wire logic [3:0]  channel_tag_in,
  output logic      [31:0] word_out,
  output logic             word32_out
);

  // ==========================================================================
  // saturation helpers
  // ==========================================================================
  function automatic logic [24:0] sat25(input logic [26:0] v);
    if (v[26:24] != {3{v[26]}}) begin
      sat25 = v[26] ? NEG_MAX_25 : POS_MAX_25;
    end else begin
      sat25 = v[24:0];
    end
  endfunction

  function automatic logic [23:0] clamp24(input logic [24:0] v);
    if (v[24] != v[23]) begin
      clamp24 = v[24] ? NEG_CLAMP_24 : POS_CLAMP_24;
    end else begin
      clamp24 = v[23:0];
    end
  endfunction

  // ==========================================================================
  // datapath
  // ==========================================================================
  logic [26:0] scaled;
  logic [24:0] res25;

  always_comb begin
    unique case (gain_code_in)
      GAIN_X64: scaled = {raw_result_in, 2'h0};
      GAIN_X32: scaled = {raw_result_in[24], raw_result_in, 1'h0};
      default:  scaled = {{2{raw_result_in[24]}}, raw_result_in};
    endcase
    res25      = sat25(scaled);
    word32_out = 1'b1;
    unique case (format_in)
      FMT_TAG_SIGN32: word_out = {channel_tag_in, {3{res25[24]}}, res25};
      FMT_SIGN32:     word_out = {{7{res25[24]}}, res25};
      FMT_LEFT32:     word_out = {clamp24(res25), 8'h00};
      FMT_BARE24: begin
        word_out   = {8'h00, clamp24(res25)};
        word32_out = 1'b0;
      end
    endcase
  end

endmodule

// file: sim/host_model.sv
// host side model: register writes, operating-state writes and register reads
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic            op_wr_out,
  output logic      [1:0] op_out
);
  // ====================
  // idle bus
  // ====================
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    op_wr_out = 1'b0;
    op_out    = 2'h0;
  end

  // ====================
  // access tasks
  // ====================
  // released lines show the inverse so stale values are never mistaken for data
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= (a == 8'h03) ? (d | 8'h01) : d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask

  task automatic set_op(input logic [1:0] v);
    @(posedge clk_in);
    op_out    <= v;
    op_wr_out <= 1'b1;
    @(posedge clk_in);
    op_wr_out <= 1'b0;
    op_out    <= ~v;
  endtask
endmodule

// file: sim/adc_gain_autozero_format_config_tb.sv
// self-checking bench for the gain, auto-zero and output format configuration block
`timescale 1ns/1ps
module adc_gain_autozero_format_config_tb;
  import adc_cfg_pkg::*;
  localparam int N = 4;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        ref_sel = 1'b1;
  logic [24:0] raw = '0;
  logic [3:0]  tag = 4'hA;
  logic        scan_last = 1'b1;
  logic [7:0]  addr, wdata, rdata, r;
  logic        wr, rd, op_wr, az, chop, w32, valid;
  logic [1:0]  op_val, bias, op_st;
  logic [2:0]  again;
  logic [31:0] word;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          lat0, lat1;
  logic [1:0]  t_fmt [11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h2, 2'h2, 2'h3};
  logic [2:0]  t_gain [11] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h7, 3'h6, 3'h7, 3'h1};
  logic [24:0] t_raw [11] = '{25'h0001234, 25'h0900000, 25'h1700000, 25'h0001234, 25'h0900000,
    25'h1700000, 25'h0900000, 25'h0000100, 25'h0000100, 25'h0500000, 25'h1700000};
  logic [31:0] t_exp [11] = '{32'h00001234, 32'h00FFFFFF, 32'h00800000, 32'h00123400,
    32'hFFFFFF00, 32'hFF700000, 32'hA0900000, 32'h00000400, 32'h00000200, 32'h00FFFFFF,
    32'hAF700000};

  always #12.5 clk = ~clk;

  adc_gain_autozero_format_config #(.BASE_CONV_CYCLES(N)) dut_u (
    .core_clk_in(clk), .arst_n_in(arst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .op_state_wr_in(op_wr), .op_state_in(op_val),
    .internal_ref_sel_in(ref_sel), .raw_result_in(raw), .channel_tag_in(tag),
    .scan_cycle_last_in(scan_last), .reg_rdata_out(rdata), .bias_current_select_out(bias),
    .analog_gain_out(again), .input_mux_autozero_out(az), .reference_buffer_chop_out(chop),
    .op_state_out(op_st), .data_word_out(word), .data_word32_out(w32), .data_valid_out(valid));

  host_model host_u (
    .clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .op_wr_out(op_wr), .op_out(op_val));

  // ====================
  // helpers
  // ====================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_valid(output int lat);
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (valid !== 1'b1 && lat < 200);
    chk(32'(valid), 32'h1);
  endtask

  task automatic conv(input logic [1:0] ea, input logic [1:0] fmt, input logic [24:0] v,
                      input logic [31:0] exp_w, output int lat);
    @(posedge clk);
    raw <= v;
    host_u.write_reg(8'h04, {ea, fmt, 4'h0});
    host_u.set_op(2'h3);
    wait_valid(lat);
    chk(word, exp_w);
    chk(32'(w32), 32'(fmt != 2'h0));
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ====================
  // watchdog
  // ====================
  initial begin
    #(25 * 20000);
    error_cnt++;
    end_of_test();
  end

  // ====================
  // tests
  // ====================
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(negedge clk);
    host_u.read_reg(8'h03, r);
    chk(32'(r), 32'h8B);
    host_u.read_reg(8'h04, r);
    chk(32'(r), 32'h00);
    chk(32'(op_st), 32'h0);
    chk(32'({az, chop, bias, 1'b0, again}), 32'h61);
    for (int g = 0; g < 8; g++) begin
      host_u.write_reg(8'h03, {2'(g), 3'(g), 3'h3});
      repeat (2) @(negedge clk);
      chk(32'(again), (g >= 6) ? 32'h5 : 32'(g));
      chk(32'(bias), 32'(g % 4));
    end
    @(posedge clk);
    ref_sel <= 1'b0;
    repeat (2) @(negedge clk);
    chk(32'(chop), 32'h0);
    @(posedge clk);
    ref_sel <= 1'b1;
    host_u.write_reg(8'h03, 8'h88);
    repeat (2) @(negedge clk);
    chk(32'(chop), 32'h0);
    host_u.read_reg(8'h03, r);
    chk(32'(r), 32'h89);
    host_u.write_reg(8'h07, 8'h55);
    host_u.read_reg(8'h07, r);
    chk(32'(r), 32'h00);
    for (int i = 0; i < 11; i++) begin
      host_u.write_reg(8'h03, {2'h2, t_gain[i], 3'h3});
      conv(2'(i % 2), t_fmt[i], t_raw[i], t_exp[i], lat0);
      chk(32'(op_st), 32'h0);
    end
    host_u.write_reg(8'h03, 8'h8F);
    repeat (2) @(negedge clk);
    chk(32'(az), 32'h1);
    conv(2'h2, 2'h0, 25'h0000010, 32'h00000010, lat1);
    chk(32'(lat1 - lat0), 32'(N));
    chk(32'(op_st), 32'h2);
    host_u.write_reg(8'h03, 8'h8B);
    @(posedge clk);
    scan_last <= 1'b0;
    conv(2'h2, 2'h0, 25'h0000010, 32'h00000010, lat0);
    chk(32'(op_st), 32'h3);
    @(posedge clk);
    scan_last <= 1'b1;
    wait_valid(lat0);
    chk(32'(op_st), 32'h2);
    conv(2'h3, 2'h2, 25'h1FFFFF0, 32'hFFFFFFF0, lat0);
    chk(32'(op_st), 32'h3);
    wait_valid(lat0);
    chk(32'(op_st), 32'h3);
    host_u.set_op(2'h0);
    host_u.write_reg(8'h03, 8'h8F);
    conv(2'h3, 2'h0, 25'h0000010, 32'h00000010, lat1);
    wait_valid(lat1);
    chk(32'(op_st), 32'h3);
    chk(32'(lat1 - lat0), 32'(N + 2));
    host_u.set_op(2'h0);
    @(negedge clk);
    chk(32'(op_st), 32'h0);
    end_of_test();
  end
endmodule
